/* verilog/ssf_top.sv */
// Serial frame sequencer with AHB-Lite register access
//
// How it works
// - Polarity low: idle clock low, select high, transmit low.
// - Idle clock pad driven as master, released as slave.
// - Master starts with select low and transmit buffer on when data waits.
// - Polarity low phase zero: data half bit after select, rise later.
// - Select returns high one bit period after the last capture.
// - Phase zero back to back: select pulses high between words.
// - Polarity low phase one: first edge rises and presents data.
// - Phase one back to back: select stays low between words.
// - Polarity high: idle clock high, select high, transmit low.
// - Polarity high phase zero: data half bit after select, fall later.
// - Polarity high phase one: first edge falls and presents data.
// - Control-word frames send eight control bits and keep nothing received during them.
// - Writing a control byte starts a frame, MSB out at select fall.
// - Control-word select stays low all frame.
// - Control-word replies latched on rising edges, changed on falling.
// - Single control-word frame: select high and word stored one period on.
// - Chained control-word frames: next byte follows, reply stored on fall.
// - Words are 4 to 16 bits, MSB first; the size field here accepts any length from 1 to 16.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
module ssf_top (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Serial pins
  input  wire ssf_pkg::ssf_pin_in_t pin_in,
  output ssf_pkg::ssf_pins_t        pins
);

  import ssf_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_ACTIVE, S_TAIL, S_GAP
  } ssf_state_t;

  ssf_cfg_t    cfg;
  logic [7:0]  presc;
  logic [15:0] tx_hold;
  logic        tx_full;
  logic [15:0] rx_word;
  logic        rx_valid;
  logic        overrun;
  ssf_state_t  state;
  logic [15:0] txsh;
  logic [15:0] rxsh;
  logic [4:0]  caps_left;
  logic        tail_half;
  ssf_pin_in_t sin;
  logic        sclk_d;
  logic        fss_d;
  logic        dp_wr;
  logic [11:0] dp_addr;
  logic        tick;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic        run;

  ssf_sync #(
    .W (3)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pin_in),
    .q       (sin)
  );

  ssf_bitdiv #(
    .CW (16)
  ) u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (run),
    .presc     (presc),
    .scr       (cfg.scr),
    .half_tick (tick)
  );

  // Bus decode
  wire        ahb_go   = hsel & htrans[1] & hready;
  wire        rd_go    = ahb_go & ~hwrite;
  wire [11:0] ap_addr  = haddr[11:0];
  wire        wr_ctrl  = dp_wr & (dp_addr == SSF_CTRL_OFS);
  wire        wr_presc = dp_wr & (dp_addr == SSF_PRESC_OFS);
  wire        wr_data  = dp_wr & (dp_addr == SSF_DATA_OFS);
  wire        rd_data  = rd_go & (ap_addr == SSF_DATA_OFS);
  wire        rd_stat  = rd_go & (ap_addr == SSF_STAT_OFS);
  wire [31:0] rd_mux   =
    (ap_addr == SSF_CTRL_OFS)  ? ctrl_rd :
    (ap_addr == SSF_PRESC_OFS) ? {24'h000000, presc} :
    (ap_addr == SSF_DATA_OFS)  ? {16'h0000, rx_word} :
    (ap_addr == SSF_STAT_OFS)  ? stat_rd : 32'h00000000;

  // Frame shape; control-word frames run as polarity low, phase zero
  wire        master   = ~cfg.slave;
  wire        pol      = cfg.pol & ~cfg.cw;
  wire        pha      = cfg.pha & ~cfg.cw;
  wire [4:0]  nbits    = {1'b0, cfg.size_m1} + 5'h01;
  wire [4:0]  total    = cfg.cw ? nbits + SSF_CTRL_BITS + SSF_WAIT_BITS
                                : nbits;
  wire [15:0] aligned  = cfg.cw ? {tx_hold[7:0], 8'h00}
                                : tx_hold << (5'h10 - nbits);
  wire [15:0] ld_word  = tx_full ? aligned : 16'h0000;
  wire [15:0] rx_mask  = 16'hffff >> (5'h10 - nbits);
  wire [15:0] rx_next  = {rxsh[14:0], sin.rx};
  assign run = master & (state != S_IDLE);

  // Master edges: leading edge leaves the idle level
  wire        m_act    = tick & (state == S_ACTIVE);
  wire        m_lead   = pins.sclk_o == pol;
  wire        capture  = m_act & (m_lead ^ pha);
  wire        shift    = m_act & ~(m_lead ^ pha);
  wire        last_cap = capture & (caps_left == 5'h01);
  wire        start    = master & cfg.en & tx_full & (state == S_IDLE);
  wire        spi_chn  = pha & tx_full;
  wire        cw_chn   = cfg.cw & tx_full & ~tail_half;
  wire        m_tail   = master & tick & (state == S_TAIL);

  // Slave edges, seen through the synchroniser
  wire        s_on     = cfg.en & cfg.slave;
  wire        s_sel    = s_on & ~sin.fss;
  wire        s_begin  = s_sel & fss_d;
  wire        s_edge   = s_sel & ~s_begin & (sin.sclk != sclk_d);
  wire        s_lead   = sclk_d == pol;
  wire        s_cap    = s_edge & (s_lead ^ pha);
  wire        s_shift  = s_edge & ~(s_lead ^ pha);
  wire        s_last   = s_cap & (caps_left == 5'h01);

  // Bits gathered before the last nbits captures of a word are masked away
  wire        push_spi = (master & last_cap & ~cfg.cw) | s_last;
  wire        push_cw  = m_tail & cfg.cw & (cw_chn | tail_half);
  wire        push     = push_spi | push_cw;
  wire [15:0] push_wd  = push_cw ? rxsh & rx_mask
                                 : rx_next & rx_mask;
  wire        load     = start | (last_cap & spi_chn & ~cfg.cw)
                       | (m_tail & cw_chn) | s_begin | (s_last & pha);

  always_comb begin
    ctrl_rd = 32'h00000000;
    ctrl_rd[SSF_EN_POS]         = cfg.en;
    ctrl_rd[SSF_SLAVE_POS]      = cfg.slave;
    ctrl_rd[SSF_CW_POS]         = cfg.cw;
    ctrl_rd[SSF_POL_POS]        = cfg.pol;
    ctrl_rd[SSF_PHA_POS]        = cfg.pha;
    ctrl_rd[SSF_SIZE_LSB +: 4]  = cfg.size_m1;
    ctrl_rd[SSF_SCR_LSB +: 8]   = cfg.scr;
    stat_rd = 32'h00000000;
    stat_rd[SSF_ST_TXFULL]      = tx_full;
    stat_rd[SSF_ST_RXVAL]       = rx_valid;
    stat_rd[SSF_ST_BUSY]        = (state != S_IDLE) | s_sel;
    stat_rd[SSF_ST_OVR]         = overrun;
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr     <= 1'b0;
      dp_addr   <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr     <= ahb_go & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ahb_go) begin
        dp_addr <= ap_addr;
      end
      if (rd_go) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Settings; meant to change only while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg   <= '{scr: SSF_SCR_RST, size_m1: SSF_SIZE_RST, default: 1'b0};
      presc <= SSF_PRESC_RST;
    end else begin
      if (wr_ctrl) begin
        cfg.en      <= hwdata[SSF_EN_POS];
        cfg.slave   <= hwdata[SSF_SLAVE_POS];
        cfg.cw      <= hwdata[SSF_CW_POS];
        cfg.pol     <= hwdata[SSF_POL_POS];
        cfg.pha     <= hwdata[SSF_PHA_POS];
        cfg.size_m1 <= hwdata[SSF_SIZE_LSB +: 4];
        cfg.scr     <= hwdata[SSF_SCR_LSB +: 8];
      end
      if (wr_presc) begin
        presc <= hwdata[7:0];
      end
    end
  end

  // Word holding; a new write beats a same-cycle load, a new push a same-cycle read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hold  <= 16'h0000;
      tx_full  <= 1'b0;
      rx_word  <= 16'h0000;
      rx_valid <= 1'b0;
      overrun  <= 1'b0;
      sclk_d   <= 1'b1;
      fss_d    <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_hold <= hwdata[15:0];
      end
      tx_full  <= wr_data | (tx_full & ~load);
      if (push) begin
        rx_word <= push_wd;
      end
      rx_valid <= push | (rx_valid & ~rd_data);
      overrun  <= (push & rx_valid & ~rd_data) | (overrun & ~rd_stat);
      sclk_d   <= sin.sclk;
      fss_d    <= sin.fss;
    end
  end

  // Pins and shifters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= S_IDLE;
      txsh      <= 16'h0000;
      rxsh      <= 16'h0000;
      caps_left <= 5'h00;
      tail_half <= 1'b0;
      pins      <= SSF_PINS_RST;
    end else if (cfg.slave) begin
      state        <= S_IDLE;
      pins.sclk_o  <= pol;
      pins.sclk_oe <= 1'b0;
      pins.fss_o   <= 1'b1;
      pins.fss_oe  <= 1'b0;
      pins.tx_oe   <= s_sel;
      if (!s_sel) begin
        pins.tx_o <= 1'b0;
      end else if (s_begin) begin
        txsh      <= pha ? ld_word : ld_word << 1;
        pins.tx_o <= ~pha & ld_word[15];
        caps_left <= nbits;
      end else begin
        if (s_shift) begin
          pins.tx_o <= txsh[15];
          txsh      <= txsh << 1;
        end
        if (s_cap) begin
          rxsh      <= rx_next;
          caps_left <= s_last ? nbits : caps_left - 5'h01;
        end
        if (s_last && pha) begin
          txsh <= ld_word;
        end
      end
    end else begin
      pins.sclk_oe <= 1'b1;
      pins.fss_oe  <= 1'b1;
      unique case (state)
        S_IDLE: begin
          pins.sclk_o <= pol;
          pins.fss_o  <= 1'b1;
          pins.tx_o   <= 1'b0;
          pins.tx_oe  <= 1'b0;
          if (start) begin
            pins.fss_o <= 1'b0;
            pins.tx_oe <= 1'b1;
            pins.tx_o  <= cfg.cw & ld_word[15];
            txsh       <= cfg.cw ? ld_word << 1 : ld_word;
            caps_left  <= total;
            state      <= (pha | cfg.cw) ? S_ACTIVE : S_SETUP;
          end
        end
        S_SETUP: if (tick) begin
          pins.tx_o <= txsh[15];
          txsh      <= txsh << 1;
          state     <= S_ACTIVE;
        end
        S_ACTIVE: if (tick) begin
          pins.sclk_o <= ~pins.sclk_o;
          if (shift) begin
            pins.tx_o <= txsh[15];
            txsh      <= txsh << 1;
          end
          if (capture) begin
            rxsh      <= rx_next;
            caps_left <= caps_left - 5'h01;
          end
          if (last_cap && spi_chn && !cfg.cw) begin
            txsh      <= ld_word;
            caps_left <= total;
          end else if (last_cap) begin
            state     <= S_TAIL;
            tail_half <= 1'b0;
          end
        end
        S_TAIL: if (tick) begin
          pins.sclk_o <= pol;
          tail_half   <= 1'b1;
          if (cw_chn) begin
            pins.tx_o <= ld_word[15];
            txsh      <= ld_word << 1;
            caps_left <= total;
            state     <= S_ACTIVE;
          end else if (tail_half) begin
            pins.fss_o <= 1'b1;
            pins.tx_o  <= 1'b0;
            pins.tx_oe <= 1'b0;
            state      <= S_GAP;
          end
        end
        S_GAP: if (tick) begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Checks
  property p_idle_lines;
    @(posedge hclk) disable iff (!hresetn)
    (state == S_IDLE && $past(state) == S_IDLE && master && $stable(cfg))
      |-> (pins.fss_o && !pins.tx_o && pins.sclk_o == pol);
  endproperty
  a_idle_lines: assert property (p_idle_lines)
    else $error("idle line levels wrong");

  property p_clk_pad;
    @(posedge hclk) disable iff (!hresetn)
    $rose(cfg.slave) |=> !pins.sclk_oe && !pins.fss_oe;
  endproperty
  a_clk_pad: assert property (p_clk_pad)
    else $error("slave still drives clock pad");

  property p_start;
    @(posedge hclk) disable iff (!hresetn)
    start |=> (!pins.fss_o && pins.tx_oe) ##1 !pins.fss_o;
  endproperty
  a_start: assert property (p_start)
    else $error("frame start without select or driver");

  property p_setup;
    @(posedge hclk) disable iff (!hresetn)
    (state == S_SETUP && tick)
      |=> (state == S_ACTIVE && $stable(pins.sclk_o) && !pins.fss_o);
  endproperty
  a_setup: assert property (p_setup)
    else $error("clock moved with first data bit");

  property p_end;
    @(posedge hclk) disable iff (!hresetn)
    (m_tail && tail_half && !cw_chn) |=> pins.fss_o && !pins.tx_oe;
  endproperty
  a_end: assert property (p_end)
    else $error("select not raised at frame end");

  property p_gap;
    @(posedge hclk) disable iff (!hresetn)
    (state == S_GAP) |-> (pins.fss_o && pins.fss_oe);
  endproperty
  a_gap: assert property (p_gap)
    else $error("select low between words");

  property p_chain;
    @(posedge hclk) disable iff (!hresetn)
    (master && last_cap && spi_chn && !cfg.cw)
      |=> (!pins.fss_o && state == S_ACTIVE) [*2];
  endproperty
  a_chain: assert property (p_chain)
    else $error("select left low chain");

  property p_cw_sel;
    @(posedge hclk) disable iff (!hresetn)
    (master && cfg.cw && (state == S_ACTIVE || state == S_TAIL))
      |-> (!pins.fss_o && pins.tx_oe);
  endproperty
  a_cw_sel: assert property (p_cw_sel)
    else $error("select high inside control-word frame");

  property p_count;
    @(posedge hclk) disable iff (!hresetn)
    (master && push) |-> (caps_left <= 5'h01) ##1 rx_valid;
  endproperty
  a_count: assert property (p_count)
    else $error("word stored before its last bit");

endmodule : ssf_top

/* common/ssf_pkg.sv */
// Constants and carrier types for the serial frame sequencer
package ssf_pkg;

  // Register byte offsets
  localparam logic [11:0] SSF_CTRL_OFS  = 12'h000;
  localparam logic [11:0] SSF_PRESC_OFS = 12'h004;
  localparam logic [11:0] SSF_DATA_OFS  = 12'h008;
  localparam logic [11:0] SSF_STAT_OFS  = 12'h00c;

  // Control register field positions
  localparam int SSF_EN_POS    = 0;
  localparam int SSF_SLAVE_POS = 1;
  localparam int SSF_CW_POS    = 2;
  localparam int SSF_POL_POS   = 3;
  localparam int SSF_PHA_POS   = 4;
  localparam int SSF_SIZE_LSB  = 8;
  localparam int SSF_SCR_LSB   = 16;

  // Status register bit positions
  localparam int SSF_ST_TXFULL = 0;
  localparam int SSF_ST_RXVAL  = 1;
  localparam int SSF_ST_BUSY   = 2;
  localparam int SSF_ST_OVR    = 3;

  // Reset values
  localparam logic [3:0] SSF_SIZE_RST  = 4'h7;
  localparam logic [7:0] SSF_SCR_RST   = 8'h00;
  localparam logic [7:0] SSF_PRESC_RST = 8'h02;

  // Control-word frame shape, in bit clocks
  localparam logic [4:0] SSF_CTRL_BITS = 5'h08;
  localparam logic [4:0] SSF_WAIT_BITS = 5'h01;

  typedef struct packed {
    logic [7:0] scr;
    logic [3:0] size_m1;
    logic       pha;
    logic       pol;
    logic       cw;
    logic       slave;
    logic       en;
  } ssf_cfg_t;

  typedef struct packed {
    logic sclk;
    logic fss;
    logic rx;
  } ssf_pin_in_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic fss_o;
    logic fss_oe;
    logic tx_o;
    logic tx_oe;
  } ssf_pins_t;

  localparam ssf_pins_t SSF_PINS_RST = '{
    sclk_o: 1'b0, sclk_oe: 1'b1, fss_o: 1'b1, fss_oe: 1'b1,
    tx_o: 1'b0, tx_oe: 1'b0};

endpackage : ssf_pkg

/* verilog/ssf_sync.sv */
// Two-flop synchroniser for pad inputs
module ssf_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Raw and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta[i] <= 1'b1;
        q[i]    <= 1'b1;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule : ssf_sync

/* verilog/ssf_bitdiv.sv */
// Half-bit enable generator for the serial bit clock
module ssf_bitdiv #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Divider control
  input  wire logic       run,
  input  wire logic [7:0] presc,
  input  wire logic [7:0] scr,
  // One-cycle pulse every half bit period
  output logic            half_tick
);

  logic [CW-1:0] cnt;

  // Prescale is even, so half of it times (1 + scr) is one half bit
  wire [15:0] p_half  = (presc[7:1] == 7'h00) ? 16'h0001
                                              : {9'h000, presc[7:1]};
  wire [15:0] scr_p1  = {8'h00, scr} + 16'h0001;
  wire [15:0] prod    = p_half * scr_p1;
  wire [CW-1:0] limit = CW'(prod - 16'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt       <= '0;
      half_tick <= 1'b0;
    end else if (!run) begin
      cnt       <= '0;
      half_tick <= 1'b0;
    end else begin
      half_tick <= (cnt == limit);
      cnt       <= (cnt == limit) ? '0 : cnt + CW'(1);
    end
  end

endmodule : ssf_bitdiv

/* dv/ssf_peer.sv */
// Behavioural off-chip serial peer: slave for the clocked and control-word formats
module ssf_peer (
  // Link pins
  input  wire logic        serial_bit_clock,
  input  wire logic        frame_select_line,
  input  wire logic        serial_transmit_line,
  output logic             serial_receive_line,
  // Behaviour settings
  input  wire logic        pol,
  input  wire logic        pha,
  input  wire logic        cw,
  input  wire logic        early_rel,
  input  wire logic [4:0]  n,
  input  wire logic [15:0] reply,
  // What was seen
  output logic [15:0]      got,
  output logic [63:0]      t_cap
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh;
  int          cnt;
  int          r;
  wire logic   cap = serial_bit_clock ^ pol ^ pha;

  initial begin
    serial_receive_line = 1'b0;
    sh = '0;
    got = '0;
    t_cap = '0;
    cnt = 0;
    r = 0;
  end

  always @(negedge frame_select_line) begin
    cnt = 0;
    r = 0;
    if (!pha && !cw)
      serial_receive_line <= reply[n-1];
  end

  // A released line must not keep the old bit, so it flips
  always @(posedge frame_select_line)
    serial_receive_line <= ~serial_receive_line;

  always @(posedge cap) if (!cw && !frame_select_line) begin
    sh = {sh[14:0], serial_transmit_line};
    cnt++;
    t_cap = $time;
    if (cnt == int'(n)) begin
      got = sh & (16'hffff >> (16 - n));
      cnt = 0;
    end
  end

  always @(negedge cap) if (!cw && !frame_select_line)
    serial_receive_line <= reply[n-1-cnt];

  always @(posedge serial_bit_clock) if (cw && !frame_select_line) begin
    if (r < 8)
      sh = {sh[14:0], serial_transmit_line};
    t_cap = $time;
    if (r == 8 + int'(n)) begin
      got = sh & 16'h00ff;
      r = 0;
    end else
      r++;
  end

  // Reply after one idle clock; line flips while not driven
  always @(negedge serial_bit_clock) if (cw && !frame_select_line) begin
    if (r >= 9)
      serial_receive_line <= reply[n-1-(r-9)];
    else if (early_rel || r != 0)
      serial_receive_line <= ~serial_receive_line;
  end
endmodule : ssf_peer

/* dv/ssf_top_tb.sv */
// Self-checking bench for the serial frame sequencer
module ssf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ssf_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  ssf_pin_in_t pin_in;
  ssf_pins_t pins;
  logic m_sclk, m_fss, m_mosi, miso, p_pol, p_pha, p_cw, p_slv, p_early;
  logic [4:0] p_n;
  logic [15:0] p_reply, got;
  logic [63:0] t_cap, t_fss;
  int n_mismatch, n_tests, n_rise, cyc;
  wire logic sclk_w = pins.sclk_oe ? pins.sclk_o : m_sclk;
  wire logic fss_w = pins.fss_oe ? pins.fss_o : m_fss;
  assign pin_in = '{sclk: sclk_w, fss: fss_w, rx: p_slv ? m_mosi : miso};

  ssf_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pins(pins));
  ssf_peer i_peer (.serial_bit_clock(sclk_w), .frame_select_line(fss_w),
    .serial_transmit_line(pins.tx_o), .serial_receive_line(miso),
    .pol(p_pol), .pha(p_pha), .cw(p_cw), .early_rel(p_early), .n(p_n),
    .reply(p_reply), .got(got), .t_cap(t_cap));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge fss_w) begin
    t_fss = $time;
    n_rise++;
  end
  // Cuts a hang short well above the expected run length
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic setup(input logic pl, ph, c, s, input logic [4:0] n_i,
                       input logic [15:0] rw);
    logic [31:0] rd;
    p_pol <= pl;
    p_pha <= ph;
    p_cw <= c;
    p_slv <= s;
    p_n <= n_i;
    p_reply <= rw;
    ahb(1'b1, SSF_CTRL_OFS, 32'h1 | 32'(s) << SSF_SLAVE_POS
      | 32'(c) << SSF_CW_POS | 32'(pl) << SSF_POL_POS
      | 32'(ph) << SSF_PHA_POS | 32'(n_i - 5'd1) << SSF_SIZE_LSB, rd);
    n_rise = 0;
  endtask : setup

  task automatic wait_idle;
    logic [31:0] rd;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, SSF_STAT_OFS, 32'h0, rd);
      if (rd[SSF_ST_BUSY] === 1'b0 && rd[SSF_ST_TXFULL] === 1'b0) return;
    end
    // Still busy after the poll limit: counted as a failure
    chk({rd[SSF_ST_BUSY], rd[SSF_ST_TXFULL]}, 32'h0);
  endtask : wait_idle

  task automatic t_reset;
    logic [31:0] rd;
    chk({pins.sclk_o, pins.sclk_oe, pins.fss_o, pins.tx_o}, 4'h6);
    chk({hreadyout, hresp}, 32'h2);
    ahb(1'b0, SSF_CTRL_OFS, 32'h0, rd);
    chk(rd, 32'(SSF_SIZE_RST) << SSF_SIZE_LSB);
    ahb(1'b0, SSF_PRESC_OFS, 32'h0, rd);
    chk(rd, 32'(SSF_PRESC_RST));
    ahb(1'b1, 12'h010, 32'hffff_ffff, rd);
    ahb(1'b0, 12'h010, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : t_reset

  task automatic t_spi(input logic pl, ph, input logic [4:0] n_i,
                       input logic [15:0] tw, rw);
    logic [31:0] rd;
    logic [15:0] m;
    m = 16'hffff >> (16 - n_i);
    setup(pl, ph, 1'b0, 1'b0, n_i, rw);
    ahb(1'b1, SSF_DATA_OFS, {16'h0, tw}, rd);
    for (int i = 0; i < 60 && fss_w !== 1'b0; i++) @(posedge hclk);
    @(posedge hclk);
    chk(pins.tx_oe, 1'b1);
    wait_idle();
    chk(got, tw & m);
    ahb(1'b0, SSF_DATA_OFS, 32'h0, rd);
    chk(rd, rw & m);
    chk(32'(t_fss - t_cap), 32'd240);
    chk({pins.sclk_o, pins.sclk_oe, pins.fss_o, pins.tx_o}, {pl, 3'b110});
  endtask : t_spi

  task automatic t_b2b(input logic ph);
    logic [31:0] rd;
    setup(1'b0, ph, 1'b0, 1'b0, 5'd8, 16'h0081);
    ahb(1'b1, SSF_DATA_OFS, 32'h0000_0096, rd);
    ahb(1'b1, SSF_DATA_OFS, 32'h0000_003c, rd);
    wait_idle();
    chk(n_rise, ph ? 32'd1 : 32'd2);
    chk(got, 16'h003c);
  endtask : t_b2b

  task automatic t_cw(input logic [4:0] n_i, input logic er, two);
    logic [31:0] rd;
    setup(1'b0, 1'b0, 1'b1, 1'b0, n_i, 16'hb5e9);
    p_early <= er;
    ahb(1'b1, SSF_DATA_OFS, 32'h0000_00c5, rd);
    if (two)
      ahb(1'b1, SSF_DATA_OFS, 32'h0000_003a, rd);
    wait_idle();
    chk(got, two ? 16'h003a : 16'h00c5);
    ahb(1'b0, SSF_DATA_OFS, 32'h0, rd);
    chk(rd, 16'hb5e9 & (16'hffff >> (16 - n_i)));
    chk(n_rise, 32'd1);
    chk(32'(t_fss - t_cap), 32'd240);
  endtask : t_cw

  // Bench plays master with a 320 ns bit clock
  task automatic t_slave;
    logic [31:0] rd;
    logic [7:0] s;
    setup(1'b0, 1'b0, 1'b0, 1'b1, 5'd8, 16'h0);
    // Pads follow the new mode one edge after the write lands
    repeat (2) @(posedge hclk);
    chk({pins.sclk_oe, pins.fss_oe}, 32'h0);
    ahb(1'b1, SSF_DATA_OFS, 32'h0000_00a6, rd);
    m_fss <= 1'b0;
    // Select leads the first sampling edge by two bit periods
    repeat (12) @(posedge hclk);
    for (int i = 7; i >= 0; i--) begin
      m_mosi <= i[0] ^ i[1];
      repeat (4) @(posedge hclk);
      s[i] = pins.tx_o;
      m_sclk <= 1'b1;
      repeat (4) @(posedge hclk);
      m_sclk <= 1'b0;
    end
    repeat (8) @(posedge hclk);
    m_fss <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(s, 8'ha6);
    ahb(1'b0, SSF_DATA_OFS, 32'h0, rd);
    chk(rd, 32'h0000_0066);
  endtask : t_slave

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    logic [31:0] rd;
    {hresetn, hsel, hwrite, m_sclk, m_mosi, p_pol, p_pha, p_cw} = '0;
    {p_slv, p_early, p_n, p_reply} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    m_fss = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    ahb(1'b1, SSF_PRESC_OFS, 32'h0000_0006, rd);
    t_spi(1'b0, 1'b0, 5'd4, 16'h000a, 16'h0005);
    t_spi(1'b0, 1'b1, 5'd16, 16'hc3a5, 16'h5a3c);
    t_spi(1'b1, 1'b0, 5'd8, 16'h00b2, 16'h004d);
    t_spi(1'b1, 1'b1, 5'd11, 16'h0555, 16'h02aa);
    t_b2b(1'b0);
    t_b2b(1'b1);
    t_cw(5'd4, 1'b1, 1'b0);
    t_cw(5'd16, 1'b0, 1'b0);
    t_cw(5'd8, 1'b1, 1'b1);
    t_slave();
    summarize();
  end
endmodule : ssf_top_tb
